/* File: shared/drst_pkg.sv */
`default_nettype none
package drst_pkg;

	// ****************************************
	// Clock and reset-line timing
	// ****************************************
	localparam int CLK_MHZ          = 200;
	localparam int REJECT_US        = 5;
	localparam int ACCEPT_MAX_US    = 9;
	localparam int SPIKE_US         = 5;
	localparam int REJECT_CYC       = REJECT_US * CLK_MHZ;
	localparam int ACCEPT_MAX_CYC   = ACCEPT_MAX_US * CLK_MHZ;
	localparam int SPIKE_CYC        = SPIKE_US * CLK_MHZ;
	localparam int FILT_W           = 12;

	// ****************************************
	// Post-release timing
	// ****************************************
	localparam int LOAD_START_MS    = 5;
	localparam int SLEEP_RELEASE_MS = 5;
	localparam int AWAKE_RELEASE_MS = 120;
	localparam int BLANK_MS         = 120;
	localparam int LOAD_START_CYC   = LOAD_START_MS * 1000 * CLK_MHZ;
	localparam int SLEEP_RELEASE_CYC = SLEEP_RELEASE_MS * 1000 * CLK_MHZ;
	localparam int AWAKE_RELEASE_CYC = AWAKE_RELEASE_MS * 1000 * CLK_MHZ;
	localparam int BLANK_CYC        = BLANK_MS * 1000 * CLK_MHZ;
	localparam int TIME_W           = 25;

	// ****************************************
	// Settings load
	// ****************************************
	localparam int NVM_WORDS        = 8;
	localparam int NVM_AW           = 3;
	localparam int NVM_DW           = 8;
	localparam logic AWAKE_RESET    = 1'b0;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		DRST_ST_RESET = 2'b00,
		DRST_ST_LOAD  = 2'b01,
		DRST_ST_DRAIN = 2'b10,
		DRST_ST_RUN   = 2'b11
	} drst_state_e;

endpackage
`default_nettype wire

/* File: design/drst_glitch_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module drst_glitch_filter #(
	parameter int ACCEPT_CYC = drst_pkg::REJECT_CYC,
	parameter int SPIKE_CYC  = drst_pkg::SPIKE_CYC,
	parameter int W          = drst_pkg::FILT_W
) (
	input  wire logic clock_i,
	input  wire logic reset_i,
	input  wire logic reset_line_n_i,
	output var  logic rst_active_o
);
	import drst_pkg::*;

	typedef struct packed {
		logic         active;
		logic [W-1:0] cnt;
	} drst_filt_s;

	drst_filt_s st;
	drst_filt_s next_st;

	// ****************************************
	// Low and high persistence counting
	// ****************************************
	always_comb
	begin
		next_st = st;
		if (!st.active)
		begin
			// Lows under the accept count are noise; no partial credit kept
			if (reset_line_n_i)
				next_st.cnt = '0;
			else if (st.cnt == W'(ACCEPT_CYC - 1))
			begin
				next_st.active = 1'b1;
				next_st.cnt    = '0;
			end
			else
				next_st.cnt = st.cnt + W'(1);
		end
		else
		begin
			// A short high inside a valid pulse neither ends nor restarts it
			if (!reset_line_n_i)
				next_st.cnt = '0;
			else if (st.cnt == W'(SPIKE_CYC - 1))
			begin
				next_st.active = 1'b0;
				next_st.cnt    = '0;
			end
			else
				next_st.cnt = st.cnt + W'(1);
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign rst_active_o = st.active;

endmodule // drst_glitch_filter
`default_nettype wire

/* File: design/drst_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Reset line is active low; logic initialises while it is held low.
// - Lows under 5us are ignored; lows over 9us always start a reset.
// - Brief highs during a valid reset pulse neither end nor restart it.
// - After release, identification, electrode voltage and settings load from NVM.
// - The settings load repeats on every release, starting within 5ms.
// - Reset while awake runs a blanking sequence ending within 120ms.
// - Reset while asleep keeps the display blank throughout.
// - On completion all registers and states hold their hardware-reset defaults.
// - Reset from sleep completes, load included, within 5ms of release.
// - Reset from awake completes, blanking and load included, within 120ms.
module drst_sequencer #(
	parameter int SLEEP_REL_CYC = drst_pkg::SLEEP_RELEASE_CYC,
	parameter int AWAKE_REL_CYC = drst_pkg::AWAKE_RELEASE_CYC,
	parameter int BLANK_SEQ_CYC = drst_pkg::BLANK_CYC,
	parameter int NVM_WORDS     = drst_pkg::NVM_WORDS
) (
	input  wire logic                       clock_i,
	input  wire logic                       reset_i,
	input  wire logic                       reset_line_n_i,
	input  wire logic [drst_pkg::NVM_DW-1:0] nvm_rd_data_i,
	input  wire logic                       cmd_valid_i,
	input  wire logic                       cmd_sleep_out_i,
	input  wire logic                       cmd_sleep_in_i,
	output var  logic                       rst_active_o,
	output var  logic                       regs_default_o,
	output var  logic                       blank_o,
	output var  logic                       blank_seq_o,
	output var  logic                       nvm_rd_o,
	output var  logic [drst_pkg::NVM_AW-1:0] nvm_addr_o,
	output var  logic                       cfg_we_o,
	output var  logic [drst_pkg::NVM_AW-1:0] cfg_addr_o,
	output var  logic [drst_pkg::NVM_DW-1:0] cfg_data_o,
	output var  logic                       busy_o,
	output var  logic                       awake_o,
	output var  logic                       cmd_accept_o,
	output var  logic                       cmd_reject_o
);
	import drst_pkg::*;

	typedef struct packed {
		drst_state_e         fsm;
		logic                rst_q;
		logic                awake;
		logic                blank;
		logic                blank_seq;
		logic [TIME_W-1:0]   blank_cnt;
		logic [TIME_W-1:0]   rel_cnt;
		logic [NVM_AW-1:0]   load_idx;
		logic                nvm_rd;
		logic [NVM_AW-1:0]   nvm_addr;
		logic                cfg_we;
		logic [NVM_AW-1:0]   cfg_addr;
		logic [NVM_DW-1:0]   cfg_data;
		logic                busy;
		logic                cmd_accept;
		logic                cmd_reject;
	} drst_seq_s;

	localparam logic [TIME_W-1:0] SLEEP_REL_T = TIME_W'(SLEEP_REL_CYC);
	localparam logic [TIME_W-1:0] AWAKE_REL_T = TIME_W'(AWAKE_REL_CYC);
	localparam logic [TIME_W-1:0] BLANK_T     = TIME_W'(BLANK_SEQ_CYC - 1);
	localparam logic [NVM_AW-1:0] LAST_IDX    = NVM_AW'(NVM_WORDS - 1);

	drst_seq_s st;
	drst_seq_s next_st;
	logic      rst_active;
	logic      cmd_window;
	logic      wake_window;
	logic      done;

	// ****************************************
	// Reset line filtering
	// ****************************************
	drst_glitch_filter #(
		.ACCEPT_CYC (REJECT_CYC),
		.SPIKE_CYC  (SPIKE_CYC),
		.W          (FILT_W)
	) u_filter (
		.clock_i        (clock_i),
		.reset_i        (reset_i),
		.reset_line_n_i (reset_line_n_i),
		.rst_active_o   (rst_active)
	);

	// ****************************************
	// Sequencing
	// ****************************************
	assign cmd_window  = (st.rel_cnt >= SLEEP_REL_T);
	assign wake_window = (st.rel_cnt >= AWAKE_REL_T);
	assign done        = (st.fsm == DRST_ST_RUN) && !st.blank_seq;

	always_comb
	begin
		next_st            = st;
		next_st.rst_q      = rst_active;
		next_st.nvm_rd     = 1'b0;
		next_st.cfg_we     = 1'b0;
		next_st.cmd_accept = 1'b0;
		next_st.cmd_reject = 1'b0;

		// Read data is valid in the same cycle as the registered strobe, so it is captured here
		if (st.nvm_rd && !rst_active)
		begin
			next_st.cfg_we   = 1'b1;
			next_st.cfg_addr = st.nvm_addr;
			next_st.cfg_data = nvm_rd_data_i;
		end

		// Blanking only starts when the pulse is taken while awake
		if (rst_active && !st.rst_q && st.awake)
		begin
			next_st.blank_seq = 1'b1;
			next_st.blank_cnt = '0;
		end
		else if (st.blank_seq)
		begin
			if (st.blank_cnt == BLANK_T)
				next_st.blank_seq = 1'b0;
			else
				next_st.blank_cnt = st.blank_cnt + TIME_W'(1);
		end

		if (st.rel_cnt != AWAKE_REL_T)
			next_st.rel_cnt = st.rel_cnt + TIME_W'(1);

		// Every command gets an answer; early ones are dropped rather than queued
		if (cmd_valid_i)
		begin
			if (rst_active || !done || !cmd_window)
				next_st.cmd_reject = 1'b1;
			else if (cmd_sleep_out_i && !wake_window)
				next_st.cmd_reject = 1'b1;
			else
			begin
				next_st.cmd_accept = 1'b1;
				if (cmd_sleep_out_i)
					next_st.awake = 1'b1;
				else if (cmd_sleep_in_i)
					next_st.awake = 1'b0;
			end
		end

		case (st.fsm)
			DRST_ST_RESET:
			begin
				next_st.rel_cnt  = '0;
				next_st.load_idx = '0;
				// Load begins on the first cycle after release, well inside 5ms
				if (!rst_active)
					next_st.fsm = DRST_ST_LOAD;
			end
			DRST_ST_LOAD:
			begin
				next_st.nvm_rd   = 1'b1;
				next_st.nvm_addr = st.load_idx;
				next_st.load_idx = st.load_idx + NVM_AW'(1);
				if (st.load_idx == LAST_IDX)
					next_st.fsm = DRST_ST_DRAIN;
			end
			DRST_ST_DRAIN:
			begin
				next_st.fsm = DRST_ST_RUN;
			end
			DRST_ST_RUN:
			begin
				next_st.fsm = DRST_ST_RUN;
			end
			default:
			begin
				next_st.fsm = DRST_ST_RESET;
			end
		endcase

		// A taken pulse overrides everything: defaults, asleep, no load
		if (rst_active)
		begin
			next_st.fsm      = DRST_ST_RESET;
			next_st.awake    = AWAKE_RESET;
			next_st.nvm_rd   = 1'b0;
			next_st.cfg_we   = 1'b0;
			next_st.rel_cnt  = '0;
			next_st.load_idx = '0;
		end

		next_st.blank = rst_active || next_st.blank_seq || !next_st.awake;
		next_st.busy  = rst_active || (next_st.fsm != DRST_ST_RUN) || next_st.blank_seq
		                || (next_st.rel_cnt < SLEEP_REL_T);
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			st       <= '0;
			st.fsm   <= DRST_ST_LOAD;
			st.blank <= 1'b1;
			st.busy  <= 1'b1;
		end
		else
			st <= next_st;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rst_active_o   = st.rst_q;
	assign regs_default_o = st.rst_q;
	assign blank_o        = st.blank;
	assign blank_seq_o    = st.blank_seq;
	assign nvm_rd_o       = st.nvm_rd;
	assign nvm_addr_o     = st.nvm_addr;
	assign cfg_we_o       = st.cfg_we;
	assign cfg_addr_o     = st.cfg_addr;
	assign cfg_data_o     = st.cfg_data;
	assign busy_o         = st.busy;
	assign awake_o        = st.awake;
	assign cmd_accept_o   = st.cmd_accept;
	assign cmd_reject_o   = st.cmd_reject;

endmodule // drst_sequencer
`default_nettype wire

/* File: sim/drst_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Reset sequencer checks
// ****
module drst_assertions #(
	parameter int BLANK_SEQ_CYC = 300
) (
	input	wire logic				clock_i,
	input	wire logic				reset_i,
	input	wire logic				reset_line_n_i,
	input	wire logic				cmd_valid_i,
	input	wire logic				rst_active_o,
	input	wire logic				regs_default_o,
	input	wire logic				blank_o,
	input	wire logic				blank_seq_o,
	input	wire logic				nvm_rd_o,
	input	wire logic [drst_pkg::NVM_AW-1:0]	nvm_addr_o,
	input	wire logic				cfg_we_o,
	input	wire logic [drst_pkg::NVM_AW-1:0]	cfg_addr_o,
	input	wire logic				busy_o,
	input	wire logic				awake_o,
	input	wire logic				cmd_accept_o,
	input	wire logic				cmd_reject_o
);
	import drst_pkg::*;
	int	run;
	int	bcnt;
	logic	lvl;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Counters stand in for long repetitions, which would choke the tools
	always_ff @(posedge clock_i)
	begin
		lvl <= reset_line_n_i;
		if (reset_i || reset_line_n_i != lvl) run <= 1;
		else run <= run + 1;
		if (blank_seq_o && !reset_i) bcnt <= bcnt + 1;
		else bcnt <= 0;
	end
	reg_defaults_a: assert property (rst_active_o || regs_default_o |-> rst_active_o && regs_default_o && !nvm_rd_o && !cfg_we_o && !cmd_accept_o)
		else $error("defaults flag differs from reset state");
	blank_rst_a: assert property (rst_active_o |-> blank_o && busy_o && !awake_o)
		else $error("display not blank during reset");
	filter_low_a: assert property ($rose(rst_active_o) |-> $past(run) >= REJECT_CYC && !$past(lvl))
		else $error("reset taken without a long low");
	filter_high_a: assert property ($fell(rst_active_o) |-> $past(run) >= SPIKE_CYC && $past(lvl))
		else $error("reset ended by a short high");
	seq_awake_a: assert property ($rose(rst_active_o) && $past(awake_o) |-> blank_seq_o)
		else $error("no blanking after awake reset");
	load_start_a: assert property ($fell(rst_active_o) |=> nvm_rd_o && nvm_addr_o == 3'h0)
		else $error("settings load did not start");
	load_step_a: assert property (nvm_rd_o && nvm_addr_o != 3'h7 |=>
		rst_active_o || (nvm_rd_o && nvm_addr_o == $past(nvm_addr_o) + 3'h1))
		else $error("settings read out of order");
	cfg_follow_a: assert property (nvm_rd_o |=> rst_active_o || (cfg_we_o && cfg_addr_o == $past(nvm_addr_o)))
		else $error("setting write missing");
	cmd_answer_a: assert property (cmd_valid_i |=> cmd_accept_o != cmd_reject_o)
		else $error("command not answered once");
	busy_reject_a: assert property (cmd_valid_i && busy_o |=> cmd_reject_o)
		else $error("command taken while busy");
	blank_len_a: assert property (blank_seq_o |-> bcnt <= BLANK_SEQ_CYC)
		else $error("blanking sequence too long");
endmodule // drst_assertions
bind drst_sequencer drst_assertions #(.BLANK_SEQ_CYC(BLANK_SEQ_CYC)) chk (
	.clock_i        (clock_i),
	.reset_i        (reset_i),
	.reset_line_n_i (reset_line_n_i),
	.cmd_valid_i    (cmd_valid_i),
	.rst_active_o   (rst_active_o),
	.regs_default_o (regs_default_o),
	.blank_o        (blank_o),
	.blank_seq_o    (blank_seq_o),
	.nvm_rd_o       (nvm_rd_o),
	.nvm_addr_o     (nvm_addr_o),
	.cfg_we_o       (cfg_we_o),
	.cfg_addr_o     (cfg_addr_o),
	.busy_o         (busy_o),
	.awake_o        (awake_o),
	.cmd_accept_o   (cmd_accept_o),
	.cmd_reject_o   (cmd_reject_o)
);
`default_nettype wire

/* File: sim/drst_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Host and settings memory
// ****
module drst_host_model (
	input	wire logic				clock_i,
	input	wire logic				nvm_rd_i,
	input	wire logic [drst_pkg::NVM_AW-1:0]	nvm_addr_i,
	output	var logic				reset_line_n_o,
	output	var logic				cmd_valid_o,
	output	var logic				cmd_sleep_out_o,
	output	var logic				cmd_sleep_in_o,
	output	var logic [drst_pkg::NVM_DW-1:0]	nvm_rd_data_o
);
	import drst_pkg::*;
	logic [NVM_DW-1:0]	junk = 8'h5A;
	initial
	begin
		reset_line_n_o = 1'h1;
		cmd_valid_o = 1'h0;
		cmd_sleep_out_o = 1'h0;
		cmd_sleep_in_o = 1'h0;
	end
	// Data only valid while a read is strobed; otherwise it toggles
	always @(posedge clock_i)
		junk <= ~junk;
	always_comb
		nvm_rd_data_o = nvm_rd_i ? (8'hA0 ^ {5'h00, nvm_addr_i}) : junk;
	task automatic line(input logic v, input int n);
		reset_line_n_o <= v;
		repeat (n) @(posedge clock_i);
	endtask
	task automatic cmd(input logic so, input logic si);
		cmd_valid_o <= 1'h1;
		cmd_sleep_out_o <= so;
		cmd_sleep_in_o <= si;
		@(posedge clock_i);
		cmd_valid_o <= 1'h0;
		cmd_sleep_out_o <= 1'h0;
		cmd_sleep_in_o <= 1'h0;
	endtask
endmodule // drst_host_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import drst_pkg::*;
	localparam int SLP = 200;
	localparam int AWK = 400;
	localparam int BLK = 300;
	logic	clock_i, reset_i, reset_line_n_i, cmd_valid_i, cmd_sleep_out_i, cmd_sleep_in_i;
	logic	rst_active_o, regs_default_o, blank_o, blank_seq_o, nvm_rd_o, cfg_we_o;
	logic	busy_o, awake_o, cmd_accept_o, cmd_reject_o;
	logic [NVM_DW-1:0]	nvm_rd_data_i, cfg_data_o;
	logic [NVM_AW-1:0]	nvm_addr_o, cfg_addr_o;
	int	failures = 0, num_checks = 0, wcnt = 0, rcnt = 0, bscnt = 0, ubcnt = 0;
	drst_sequencer #(.SLEEP_REL_CYC(SLP), .AWAKE_REL_CYC(AWK), .BLANK_SEQ_CYC(BLK)) uut (
		.clock_i         (clock_i),
		.reset_i         (reset_i),
		.reset_line_n_i  (reset_line_n_i),
		.nvm_rd_data_i   (nvm_rd_data_i),
		.cmd_valid_i     (cmd_valid_i),
		.cmd_sleep_out_i (cmd_sleep_out_i),
		.cmd_sleep_in_i  (cmd_sleep_in_i),
		.rst_active_o    (rst_active_o),
		.regs_default_o  (regs_default_o),
		.blank_o         (blank_o),
		.blank_seq_o     (blank_seq_o),
		.nvm_rd_o        (nvm_rd_o),
		.nvm_addr_o      (nvm_addr_o),
		.cfg_we_o        (cfg_we_o),
		.cfg_addr_o      (cfg_addr_o),
		.cfg_data_o      (cfg_data_o),
		.busy_o          (busy_o),
		.awake_o         (awake_o),
		.cmd_accept_o    (cmd_accept_o),
		.cmd_reject_o    (cmd_reject_o)
	);
	drst_host_model host (.clock_i(clock_i), .nvm_rd_i(nvm_rd_o), .nvm_addr_i(nvm_addr_o),
		.reset_line_n_o(reset_line_n_i), .cmd_valid_o(cmd_valid_i), .cmd_sleep_out_o(cmd_sleep_out_i),
		.cmd_sleep_in_o(cmd_sleep_in_i), .nvm_rd_data_o(nvm_rd_data_i));
	initial
	begin
		clock_i = 1'h0;
		forever #2.5 clock_i = ~clock_i;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask
	always @(posedge clock_i)
	begin
		if (cfg_we_o === 1'h1)
		begin
			wcnt++;
			chk(cfg_addr_o, (wcnt - 1) % NVM_WORDS);
			chk(cfg_data_o, 8'hA0 ^ {5'h00, cfg_addr_o});
		end
		if (rst_active_o === 1'h1) rcnt++;
		if (blank_seq_o === 1'h1) bscnt++;
		if (rst_active_o === 1'h1 && blank_o !== 1'h1) ubcnt++;
	end
	task conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task wait_idle(input int n);
		for (int i = 0; i < n && busy_o !== 1'h0; i++) @(posedge clock_i);
		if (busy_o !== 1'h0)
		begin
			failures++;
			$display("mismatch at %0t: busy stuck", $time);
			conclude;
		end
	endtask
	task tcmd(input logic so, input logic si, input logic acc);
		host.cmd(so, si);
		@(posedge clock_i);
		chk(cmd_accept_o, acc);
		chk(cmd_reject_o, !acc);
	endtask
	task t_boot;
		chk({busy_o, awake_o, blank_o}, 3'h5);
		tcmd(1'h1, 1'h0, 1'h0);
		wait_idle(SLP + 20);
		chk(wcnt, 8);
		tcmd(1'h1, 1'h0, 1'h0);
		tcmd(1'h0, 1'h1, 1'h1);
		repeat (AWK) @(posedge clock_i);
		tcmd(1'h1, 1'h0, 1'h1);
		chk({awake_o, blank_o}, 2'h2);
		$display("boot done");
	endtask
	task t_spike;
		int r;
		r = rcnt;
		host.line(1'h0, REJECT_CYC - 100);
		host.line(1'h1, 20);
		chk(rcnt - r, 0);
		chk(awake_o, 1'h1);
		$display("spike done");
	endtask
	task t_awake;
		int w;
		w = wcnt;
		host.line(1'h0, 1100);
		chk({rst_active_o, blank_seq_o, awake_o}, 3'h6);
		chk(regs_default_o, 1'h1);
		tcmd(1'h0, 1'h1, 1'h0);
		host.line(1'h1, 500);
		host.line(1'h0, 1000);
		chk(rst_active_o, 1'h1);
		chk(wcnt - w, 0);
		host.line(1'h1, 1);
		wait_idle(1000 + AWK);
		chk(wcnt - w, 8);
		$display("awake reset done");
	endtask
	task t_sleep;
		int w, b, u;
		w = wcnt;
		b = bscnt;
		u = ubcnt;
		host.line(1'h0, 2100);
		host.line(1'h1, 1);
		wait_idle(1000 + SLP + 30);
		chk(bscnt - b, 0);
		chk(ubcnt - u, 0);
		chk(wcnt - w, 8);
		chk({regs_default_o, awake_o, blank_o}, 3'h1);
		$display("sleep reset done");
	endtask
	initial
	begin
		reset_i = 1'h1;
		repeat (5) @(posedge clock_i);
		reset_i <= 1'h0;
		repeat (2) @(posedge clock_i);
		t_boot;
		t_spike;
		t_awake;
		t_sleep;
		conclude;
	end
endmodule // testbench
`default_nettype wire
